// ### hw/dmd_decode.sv
// Purpose: Data-memory address decoder and low I/O register bank.
// Assumes: CPU requests come from logic on core_clk; input pins are asynchronous.
// Notes:   Read data return two edges after the request.
//
// What this block does
// RL1: Decode 205 words: 48 display, 13 I/O, rest RAM.
// RL2: Display window sits at 40H-6FH or C0H-EFH by build option.
// RL3: Lower placement overlays RAM and is readable and writable.
// RL4: Upper placement is write only; reads there return zero.
// RL5: Software keeps away from unused or unlisted addresses.
// RL6: Timer register is read-only stage bits 2/4/8/16 Hz, cleared at reset.
// RL7: Input register reads live pin levels, read-only, no reset value.
// RL8: Input interrupt enables, one per pin, read/write, reset clear.
// RL9: LCD static select plus 2/8/32 Hz timer enables, reset clear.
// RL10: Timer event flags for 2/8/32 Hz in low three bits, read-only.
// RL11: Input event flag in bit two; other bits read zero.
// RL12: Every event flag clears when the CPU reads it.
// RL13: Unused bits of implemented registers read zero.
// RL14: Writes to read-only bits are ignored.
// RL15: Rows 7 and F go to the I/O bank, other populated rows to RAM.
`timescale 1ns/1ps
module dmd_decode #(
   parameter bit DISP_UPPER = 1'b0
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst_b,
   input  dmd_pkg::dmd_cpu_req_t              cpu_req,
   output logic      [dmd_pkg::DATA_W-1:0]    cpu_rdata_ff,
   output logic                               cpu_rvalid_ff,
   input  wire logic [3:0]                    input_pins,
   input  wire logic                          peripheral_clock,
   input  wire logic [dmd_pkg::DISP_AW-1:0]   lcd_rd_addr,
   output logic      [dmd_pkg::DATA_W-1:0]    lcd_rd_data_ff,
   output logic                               lcd_static_select_ff,
   output logic                               timer_irq_req_ff,
   output logic                               input_irq_req_ff
);
   import dmd_pkg::*;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_disp_row(input logic [3:0] row);
      logic [3:0] lo;
      lo = DISP_UPPER ? (row - UPPER_ROW_ADD) : row;
      if (DISP_UPPER && row < UPPER_ROW_ADD) begin
         return 1'b0;
      end
      return (lo >= DISP_ROW_FIRST) && (lo <= DISP_ROW_LAST);               // RL2
   endfunction

   function automatic dmd_region_t region_of(input logic [ADDR_W-1:0] a);
      logic [3:0] row;
      row = a[7:4];
      if (row == IO_ROW_LO || row == IO_ROW_HI) begin
         return DMD_RGN_IO;                                                  // RL15
      end else if (is_disp_row(row)) begin
         return DMD_RGN_DISP;                                                // RL1
      end else if (row <= RAM_ROW_LAST) begin
         return DMD_RGN_RAM;                                                 // RL15
      end else if (row >= RAM2_ROW_FIRST && row <= RAM2_ROW_LAST) begin
         return DMD_RGN_RAM;                                                 // RL15
      end else begin
         return DMD_RGN_NONE;                                                // RL5
      end
   endfunction

   // ----------------------------------------------------------------
   // Input pin synchroniser
   // ----------------------------------------------------------------
   logic [3:0] pins_meta_ff;
   logic [3:0] pins_sync_ff;
   logic [3:0] pins_prev_ff;

   always_ff @(posedge core_clk) begin
      pins_meta_ff <= input_pins;
      pins_sync_ff <= pins_meta_ff;
      pins_prev_ff <= pins_sync_ff;
   end

   // ----------------------------------------------------------------
   // Clock timer
   // ----------------------------------------------------------------
   logic [3:0]   timer_stages;
   dmd_tmr_evt_t tmr_evt;

   dmd_timer u_timer (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .tick_en   (peripheral_clock),
      .stages_ff (timer_stages),
      .evt_ff    (tmr_evt)
   );

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   dmd_region_t req_rgn;
   logic        io_wr;
   logic        io_rd;
   logic        mem_wr;
   logic        disp_readable;

   assign req_rgn       = region_of(cpu_req.addr);
   assign io_wr         = cpu_req.wr && (req_rgn == DMD_RGN_IO);
   assign io_rd         = cpu_req.rd && (req_rgn == DMD_RGN_IO);
   assign disp_readable = !DISP_UPPER;                                       // RL3 RL4

   // Both RAM and display writes go to the one store; upper display is write only.
   assign mem_wr = cpu_req.wr && (req_rgn == DMD_RGN_RAM || req_rgn == DMD_RGN_DISP); // RL3 RL4

   // ----------------------------------------------------------------
   // Word store
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem_rdata;
   logic [ADDR_W-1:0] lcd_mem_addr;

   assign lcd_mem_addr = (DISP_UPPER ? DISP_BASE_HI : DISP_BASE_LO) + {2'b00, lcd_rd_addr};

   dmd_mem u_mem (
      .core_clk    (core_clk),
      .wr_en       (mem_wr),
      .wr_addr     (cpu_req.addr),
      .wr_data     (cpu_req.wdata),
      .rd_addr     (cpu_req.addr),
      .rd_data_ff  (mem_rdata),
      .lcd_addr    (lcd_mem_addr),
      .lcd_data_ff (lcd_rd_data_ff)
   );

   // ----------------------------------------------------------------
   // Read/write control registers
   // ----------------------------------------------------------------
   logic [3:0] in_irq_en_ff;
   logic [3:0] lcd_tmr_en_ff;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         in_irq_en_ff <= IN_IRQ_EN_RST;                                      // RL8
      end else if (io_wr && cpu_req.addr == IN_IRQ_EN_OFF) begin
         in_irq_en_ff <= cpu_req.wdata;                                      // RL8
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         lcd_tmr_en_ff <= LCD_TMR_EN_RST;                                    // RL9
      end else if (io_wr && cpu_req.addr == LCD_TMR_EN_OFF) begin
         lcd_tmr_en_ff <= cpu_req.wdata;                                     // RL9
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         lcd_static_select_ff <= 1'b0;
      end else begin
         lcd_static_select_ff <= lcd_tmr_en_ff[LCD_STATIC_BIT];              // RL9
      end
   end

   // Writes to the timer, pin level and flag registers have no path here.  RL14

   // ----------------------------------------------------------------
   // Event flags
   // ----------------------------------------------------------------
   logic [2:0] tmr_flags_ff;
   logic       in_flag_ff;
   logic [2:0] tmr_set;
   logic       in_set;
   logic       tmr_clr;
   logic       in_clr;

   assign tmr_set = {tmr_evt.slow, tmr_evt.mid, tmr_evt.fast};
   assign in_set  = |(pins_sync_ff & ~pins_prev_ff & in_irq_en_ff);
   assign tmr_clr = io_rd && (cpu_req.addr == TMR_FLAGS_OFF);                // RL12
   assign in_clr  = io_rd && (cpu_req.addr == IN_FLAG_OFF);                  // RL12

   // A set arriving in the same cycle as a read-clear survives the clear.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tmr_flags_ff <= TMR_FLAGS_RST;                                      // RL10
      end else begin
         tmr_flags_ff <= (tmr_clr ? 3'b000 : tmr_flags_ff) | tmr_set;        // RL10 RL12
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         in_flag_ff <= IN_FLAG_RST;                                          // RL11
      end else begin
         in_flag_ff <= (in_clr ? 1'b0 : in_flag_ff) | in_set;                // RL11 RL12
      end
   end

   // ----------------------------------------------------------------
   // Interrupt requests to the core
   // ----------------------------------------------------------------
   logic [2:0] tmr_en;

   assign tmr_en = lcd_tmr_en_ff[SLOW_BIT:FAST_BIT];

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         timer_irq_req_ff <= 1'b0;
         input_irq_req_ff <= 1'b0;
      end else begin
         timer_irq_req_ff <= |(tmr_flags_ff & tmr_en);                       // RL9
         input_irq_req_ff <= in_flag_ff;                                     // RL8
      end
   end

   // ----------------------------------------------------------------
   // I/O read mux
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] io_rdata;

   always_comb begin
      io_rdata = 4'h0;                                                       // RL13
      if (cpu_req.addr == TIMER_STAGES_OFF) begin
         io_rdata = timer_stages;                                            // RL6
      end else if (cpu_req.addr == PIN_LEVELS_OFF) begin
         io_rdata = pins_sync_ff;                                            // RL7
      end else if (cpu_req.addr == IN_IRQ_EN_OFF) begin
         io_rdata = in_irq_en_ff;                                            // RL8
      end else if (cpu_req.addr == LCD_TMR_EN_OFF) begin
         io_rdata = lcd_tmr_en_ff;                                           // RL9
      end else if (cpu_req.addr == TMR_FLAGS_OFF) begin
         io_rdata = {1'b0, tmr_flags_ff};                                    // RL10 RL13
      end else if (cpu_req.addr == IN_FLAG_OFF) begin
         io_rdata = {1'b0, in_flag_ff, 2'b00};                               // RL11 RL13
      end
   end

   // ----------------------------------------------------------------
   // Read pipeline
   // ----------------------------------------------------------------
   // Stage one holds the I/O value sampled at the request edge, so a
   // read-clear flag returns its value from before the clear.
   logic              rd_pend_ff;
   logic              rd_from_mem_ff;
   logic [DATA_W-1:0] io_rd_ff;
   logic              nxt_from_mem;

   assign nxt_from_mem = (req_rgn == DMD_RGN_RAM)
                      || (req_rgn == DMD_RGN_DISP && disp_readable);         // RL3 RL4

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rd_pend_ff     <= 1'b0;
         rd_from_mem_ff <= 1'b0;
         io_rd_ff       <= 4'h0;
      end else begin
         rd_pend_ff     <= cpu_req.rd;
         rd_from_mem_ff <= cpu_req.rd && nxt_from_mem;
         io_rd_ff       <= io_rd ? io_rdata : 4'h0;                          // RL5
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cpu_rvalid_ff <= 1'b0;
         cpu_rdata_ff  <= 4'h0;
      end else begin
         cpu_rvalid_ff <= rd_pend_ff;
         if (rd_pend_ff) begin
            cpu_rdata_ff <= rd_from_mem_ff ? mem_rdata : io_rd_ff;
         end
      end
   end

endmodule

// ### hw/dmd_mem.sv
// Purpose: Word store for RAM and display memory, one write and two read ports.
// Assumes: Single clock; read data appear one edge after the request.
// Notes:   Contents are undefined after reset, as the store has no reset.
`timescale 1ns/1ps
module dmd_mem (
   input  wire logic                          core_clk,
   input  wire logic                          wr_en,
   input  wire logic [dmd_pkg::ADDR_W-1:0]    wr_addr,
   input  wire logic [dmd_pkg::DATA_W-1:0]    wr_data,
   input  wire logic [dmd_pkg::ADDR_W-1:0]    rd_addr,
   output logic      [dmd_pkg::DATA_W-1:0]    rd_data_ff,
   input  wire logic [dmd_pkg::ADDR_W-1:0]    lcd_addr,
   output logic      [dmd_pkg::DATA_W-1:0]    lcd_data_ff
);
   import dmd_pkg::*;

   logic [DATA_W-1:0] mem [MEM_DEPTH];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge core_clk) begin
      rd_data_ff <= mem[rd_addr];
   end

   // The display port is separate so panel refresh never steals CPU cycles.
   always_ff @(posedge core_clk) begin
      lcd_data_ff <= mem[lcd_addr];
   end
endmodule

// ### hw/dmd_pkg.sv
// Purpose: Shared constants and types for the data-memory decoder and low I/O bank.
// Assumes: Page zero only; 8-bit word address, 4-bit data words.
// Notes:   All offsets, field positions, reset values and timer taps live here.
package dmd_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 4;
   localparam int MEM_DEPTH  = 256;
   localparam int DISP_AW    = 6;
   localparam int DISP_WORDS = 48;
   localparam int IO_WORDS   = 13;
   localparam int TOTAL_WORDS = 205;

   // ----------------------------------------------------------------
   // Row map (high address nibble)
   // ----------------------------------------------------------------
   localparam logic [3:0] IO_ROW_LO      = 4'h7;
   localparam logic [3:0] IO_ROW_HI      = 4'hF;
   localparam logic [3:0] RAM_ROW_LAST   = 4'h6;
   localparam logic [3:0] RAM2_ROW_FIRST = 4'h8;
   localparam logic [3:0] RAM2_ROW_LAST  = 4'h9;
   localparam logic [3:0] DISP_ROW_FIRST = 4'h4;
   localparam logic [3:0] DISP_ROW_LAST  = 4'h6;
   localparam logic [3:0] UPPER_ROW_ADD  = 4'h8;
   localparam logic [7:0] DISP_BASE_LO   = 8'h40;
   localparam logic [7:0] DISP_BASE_HI   = 8'hC0;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] TIMER_STAGES_OFF = 8'h70;
   localparam logic [7:0] PIN_LEVELS_OFF   = 8'h73;
   localparam logic [7:0] IN_IRQ_EN_OFF    = 8'h75;
   localparam logic [7:0] LCD_TMR_EN_OFF   = 8'h78;
   localparam logic [7:0] TMR_FLAGS_OFF    = 8'h79;
   localparam logic [7:0] IN_FLAG_OFF      = 8'h7A;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int LCD_STATIC_BIT = 3;
   localparam int SLOW_BIT       = 2;
   localparam int MID_BIT        = 1;
   localparam int FAST_BIT       = 0;
   localparam int IN_FLAG_BIT    = 2;

   localparam logic [3:0] TIMER_STAGES_RST = 4'h0;
   localparam logic [3:0] IN_IRQ_EN_RST    = 4'h0;
   localparam logic [3:0] LCD_TMR_EN_RST   = 4'h0;
   localparam logic [2:0] TMR_FLAGS_RST    = 3'h0;
   localparam logic       IN_FLAG_RST      = 1'b0;

   // ----------------------------------------------------------------
   // Clock timer taps: bit b of the count toggles at PERIPH_HZ / 2^(b+1)
   // ----------------------------------------------------------------
   localparam int PERIPH_HZ  = 65536;
   localparam int TMR_CNT_W  = 15;
   localparam int TAP_2HZ    = 14;
   localparam int TAP_4HZ    = 13;
   localparam int TAP_8HZ    = 12;
   localparam int TAP_16HZ   = 11;
   localparam int TAP_32HZ   = 10;
   localparam logic [TMR_CNT_W-1:0] TMR_CNT_RST = 15'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              rd;
      logic              wr;
      logic [DATA_W-1:0] wdata;
   } dmd_cpu_req_t;

   typedef struct packed {
      logic slow;
      logic mid;
      logic fast;
   } dmd_tmr_evt_t;

   typedef enum logic [1:0] {
      DMD_RGN_NONE,
      DMD_RGN_RAM,
      DMD_RGN_DISP,
      DMD_RGN_IO
   } dmd_region_t;

endpackage

// ### hw/dmd_timer.sv
// Purpose: Clock timer count, stage bits and 2/8/32 Hz event pulses.
// Assumes: tick_en is a one-cycle pulse per peripheral clock period.
// Notes:   Events mark the falling edge of the 2, 8 and 32 Hz taps, one core cycle wide.
`timescale 1ns/1ps
module dmd_timer (
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire logic                 tick_en,
   output logic [3:0]                stages_ff,
   output dmd_pkg::dmd_tmr_evt_t     evt_ff
);
   import dmd_pkg::*;

   logic [TMR_CNT_W-1:0] cnt_ff;
   logic [TMR_CNT_W-1:0] nxt_cnt;

   assign nxt_cnt = cnt_ff + 15'h0001;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cnt_ff <= TMR_CNT_RST;
      end else if (tick_en) begin
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         stages_ff <= TIMER_STAGES_RST;                                        // RL6
      end else begin
         stages_ff <= {cnt_ff[TAP_2HZ], cnt_ff[TAP_4HZ], cnt_ff[TAP_8HZ], cnt_ff[TAP_16HZ]}; // RL6
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         evt_ff <= '0;
      end else begin
         evt_ff.slow <= tick_en & cnt_ff[TAP_2HZ]  & ~nxt_cnt[TAP_2HZ];
         evt_ff.mid  <= tick_en & cnt_ff[TAP_8HZ]  & ~nxt_cnt[TAP_8HZ];
         evt_ff.fast <= tick_en & cnt_ff[TAP_32HZ] & ~nxt_cnt[TAP_32HZ];
      end
   end
endmodule

// ### tb/dmd_cpu_model.sv
// Purpose: Behavioural CPU core issuing data memory reads and writes.
// Assumes: Requests are launched just after a rising edge.
// Notes:   Reads sample the answer just after the edge that follows the request edge.
`timescale 1ns/1ps
module dmd_cpu_model (
   input wire logic              core_clk,
   output dmd_pkg::dmd_cpu_req_t cpu_req,
   input wire logic [3:0]        cpu_rdata_ff,
   input wire logic              cpu_rvalid_ff
);
   import dmd_pkg::*;
   initial begin
      cpu_req = '0;
   end
   // Between requests the strobes drop and the address stops showing the last word.
   task automatic idle();
      cpu_req <= '{addr: ~cpu_req.addr, rd: 1'b0, wr: 1'b0, wdata: ~cpu_req.wdata};
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] d);
      cpu_req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [3:0] d, output logic ok);
      cpu_req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: ~cpu_req.wdata};
      @(posedge core_clk);
      // The valid pulse stands for one cycle only, so look just after it rises.
      idle();
      #1;
      ok = cpu_rvalid_ff;
      d = cpu_rdata_ff;
   endtask
endmodule

// ### tb/dmd_decode_properties.sv
// Purpose: Concurrent checks on the decoder's CPU, LCD and interrupt ports.
// Assumes: Display in the lower window; rst_b synchronous, active low.
// Notes:   Bound to dmd_decode from the bench top file.
`timescale 1ns/1ps
module dmd_decode_properties (
   input wire logic              core_clk,
   input wire logic              rst_b,
   input dmd_pkg::dmd_cpu_req_t  cpu_req,
   input wire logic [3:0]        cpu_rdata_ff,
   input wire logic              cpu_rvalid_ff,
   input wire logic              lcd_static_select_ff,
   input wire logic              timer_irq_req_ff,
   input wire logic              input_irq_req_ff
);
   import dmd_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   // Shadow of the timer enables, so the request output can be tied to them.
   logic [2:0] tmr_en_ff;
   logic       en_nz;
   logic       rd7a;
   logic       lcd_wr;
   assign en_nz  = |tmr_en_ff;
   assign rd7a   = cpu_req.rd && (cpu_req.addr == IN_FLAG_OFF);
   assign lcd_wr = cpu_req.wr && (cpu_req.addr == LCD_TMR_EN_OFF);
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tmr_en_ff <= 3'h0;
      end else if (lcd_wr) begin
         tmr_en_ff <= cpu_req.wdata[2:0];
      end
   end
   property p_rvalid_lat;
      cpu_req.rd |-> ##2 cpu_rvalid_ff;
   endproperty
   a_rvalid_lat: assert property (p_rvalid_lat) else $error("read answer late");
   property p_no_spur;
      cpu_rvalid_ff |-> $past(cpu_req.rd, 2);
   endproperty
   a_no_spur: assert property (p_no_spur) else $error("read answer without request");
   property p_flag79;
      cpu_req.rd && (cpu_req.addr == TMR_FLAGS_OFF) |-> ##2 (cpu_rdata_ff[3] == 1'b0);
   endproperty
   a_flag79: assert property (p_flag79) else $error("timer flag word top bit set");
   property p_flag7a;
      rd7a |-> ##2 ((cpu_rdata_ff & 4'hB) == 4'h0);
   endproperty
   a_flag7a: assert property (p_flag7a) else $error("input flag word spare bits set");
   property p_unused;
      cpu_req.rd && ((cpu_req.addr[7:4] == IO_ROW_HI) ||
         (cpu_req.addr inside {8'h71, 8'h72, 8'h74, 8'h76, 8'h77})) |-> ##2 (cpu_rdata_ff == 4'h0);
   endproperty
   a_unused: assert property (p_unused) else $error("unused word read nonzero");
   property p_lcd;
      $changed(lcd_static_select_ff) |-> ($past(lcd_wr, 1) || $past(lcd_wr, 2) || $past(lcd_wr, 3));
   endproperty
   a_lcd: assert property (p_lcd) else $error("drive select changed without write");
   property p_rdata_hold;
      !cpu_rvalid_ff |-> $stable(cpu_rdata_ff);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_tmr_gate;
      timer_irq_req_ff |-> ($past(en_nz, 1) || $past(en_nz, 2));
   endproperty
   a_tmr_gate: assert property (p_tmr_gate) else $error("timer request while masked");
   property p_in_clear;
      $fell(input_irq_req_ff) |-> ($past(rd7a, 1) || $past(rd7a, 2) || $past(rd7a, 3));
   endproperty
   a_in_clear: assert property (p_in_clear) else $error("input flag cleared without read");
endmodule

// ### tb/dmd_decode_tb_top.sv
// Purpose: Self-checking bench for the data-memory decoder and I/O bank.
// Assumes: Lower display window; peripheral pulse every cycle shortens the timer.
// Notes:   A word array models RAM and display contents.
`timescale 1ns/1ps
module dmd_decode_tb_top;
   import dmd_pkg::*;
   logic                core_clk;
   logic                rst_b;
   dmd_cpu_req_t        cpu_req;
   logic [3:0]          cpu_rdata_ff;
   logic                cpu_rvalid_ff;
   logic [3:0]          input_pins;
   logic                peripheral_clock;
   logic [DISP_AW-1:0]  lcd_rd_addr;
   logic [3:0]          lcd_rd_data_ff;
   logic                lcd_static_select_ff;
   logic                timer_irq_req_ff;
   logic                input_irq_req_ff;
   logic [3:0]          mem_q [256];
   logic [7:0]          un_a [12] = '{8'h70, 8'h73, 8'h79, 8'h7A, 8'h71, 8'h74, 8'h77, 8'h7B, 8'hA5, 8'hC3,
                                      8'hE7, 8'hF6};
   int                  miscompares = 0;
   int                  compares = 0;
   int                  cycles = 0;
   int                  seed;
   int                  tcnt;
   logic [7:0]          a;
   logic [3:0]          d;
   dmd_decode #(.DISP_UPPER(1'b0)) dut_u (.core_clk(core_clk), .rst_b(rst_b), .cpu_req(cpu_req),
      .cpu_rdata_ff(cpu_rdata_ff), .cpu_rvalid_ff(cpu_rvalid_ff), .input_pins(input_pins),
      .peripheral_clock(peripheral_clock), .lcd_rd_addr(lcd_rd_addr), .lcd_rd_data_ff(lcd_rd_data_ff),
      .lcd_static_select_ff(lcd_static_select_ff), .timer_irq_req_ff(timer_irq_req_ff),
      .input_irq_req_ff(input_irq_req_ff));
   dmd_cpu_model cpu_u (.core_clk(core_clk), .cpu_req(cpu_req), .cpu_rdata_ff(cpu_rdata_ff),
      .cpu_rvalid_ff(cpu_rvalid_ff));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic end_of_test();
      if ((miscompares == 0) && (compares > 0)) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] addr, input logic [3:0] exp);
      logic [3:0] v;
      logic       ok;
      cpu_u.rd(addr, v, ok);
      chk({3'h0, ok}, 4'h1);
      chk(v, exp);
   endtask
   function automatic bit is_ram(input logic [7:0] x);
      return (x[7:4] <= RAM_ROW_LAST) || (x[7:4] == RAM2_ROW_FIRST) || (x[7:4] == RAM2_ROW_LAST);
   endfunction
   // The run is about 36000 cycles; the ceiling leaves ample margin.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      seed = 29809;
      rst_b <= 1'b0;
      peripheral_clock <= 1'b0;
      input_pins <= 4'h0;
      lcd_rd_addr <= 6'h00;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      input_pins <= 4'($random(seed));
      @(posedge core_clk);
      rdc(TIMER_STAGES_OFF, 4'h0);
      rdc(IN_IRQ_EN_OFF, 4'h0);
      rdc(LCD_TMR_EN_OFF, 4'h0);
      rdc(TMR_FLAGS_OFF, 4'h0);
      rdc(IN_FLAG_OFF, 4'h0);
      rdc(PIN_LEVELS_OFF, input_pins);
      for (int i = 0; i < 6; i++) begin
         d = 4'($random(seed));
         cpu_u.wr(IN_IRQ_EN_OFF, d);
         rdc(IN_IRQ_EN_OFF, d);
         cpu_u.wr(LCD_TMR_EN_OFF, d);
         rdc(LCD_TMR_EN_OFF, d);
         chk({3'h0, lcd_static_select_ff}, {3'h0, d[LCD_STATIC_BIT]});
      end
      foreach (un_a[i]) begin
         cpu_u.wr(un_a[i], 4'hF);
         rdc(un_a[i], (un_a[i] == PIN_LEVELS_OFF) ? input_pins : 4'h0);
      end
      // Even steps write back to back; odd steps read the word straight after writing it.
      for (int i = 0; i < 88; i++) begin
         a = (i < DISP_WORDS) ? DISP_BASE_LO + 8'(i) : 8'({$random(seed)} % 160);
         if (a[7:4] == IO_ROW_LO) a[7:4] = RAM2_ROW_FIRST;
         d = 4'($random(seed));
         mem_q[a] = d;
         cpu_u.wr(a, d);
         if (i[0]) rdc(a, d);
      end
      cpu_u.idle();
      for (int i = 0; i < 256; i++) begin
         if (is_ram(8'(i)) && (mem_q[i] !== 4'hx)) rdc(8'(i), mem_q[i]);
      end
      for (int i = 0; i < DISP_WORDS; i++) begin
         lcd_rd_addr <= 6'(i);
         @(posedge core_clk);
         #1;
         chk(lcd_rd_data_ff, mem_q[DISP_BASE_LO + i]);
      end
      cpu_u.wr(IN_IRQ_EN_OFF, 4'h0);
      input_pins <= 4'h0;
      rdc(IN_FLAG_OFF, 4'h0);
      cpu_u.wr(IN_IRQ_EN_OFF, 4'h2);
      cpu_u.idle();
      input_pins <= 4'h1;
      repeat (6) @(posedge core_clk);
      chk({3'h0, input_irq_req_ff}, 4'h0);
      input_pins <= 4'h3;
      repeat (6) @(posedge core_clk);
      chk({3'h0, input_irq_req_ff}, 4'h1);
      rdc(PIN_LEVELS_OFF, 4'h3);
      rdc(IN_FLAG_OFF, 4'h4);
      rdc(IN_FLAG_OFF, 4'h0);
      chk({3'h0, input_irq_req_ff}, 4'h0);
      cpu_u.wr(LCD_TMR_EN_OFF, 4'h0);
      cpu_u.idle();
      for (tcnt = 0; tcnt < 35000; tcnt++) begin
         peripheral_clock <= 1'b1;
         @(posedge core_clk);
      end
      peripheral_clock <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk({3'h0, timer_irq_req_ff}, 4'h0);
      cpu_u.wr(LCD_TMR_EN_OFF, 4'h1);
      cpu_u.idle();
      cpu_u.idle();
      chk({3'h0, timer_irq_req_ff}, 4'h1);
      rdc(TIMER_STAGES_OFF, 4'((tcnt % 32768) >> TAP_16HZ));
      rdc(TMR_FLAGS_OFF, 4'h7);
      rdc(TMR_FLAGS_OFF, 4'h0);
      chk({3'h0, timer_irq_req_ff}, 4'h0);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rdc(TIMER_STAGES_OFF, 4'h0);
      rdc(LCD_TMR_EN_OFF, 4'h0);
      end_of_test();
   end
endmodule
bind dmd_decode dmd_decode_properties props_u (.core_clk(core_clk), .rst_b(rst_b), .cpu_req(cpu_req),
   .cpu_rdata_ff(cpu_rdata_ff), .cpu_rvalid_ff(cpu_rvalid_ff), .lcd_static_select_ff(lcd_static_select_ff),
   .timer_irq_req_ff(timer_irq_req_ff), .input_irq_req_ff(input_irq_req_ff));
